/* inc/cgc_consts.vh */
/*
  Constants for the clock generator control block: register map, field
  positions, reset values and division limits.
  Assumes inclusion by bare name from the design file.
*/
`ifndef CGC_CONSTS_VH
`define CGC_CONSTS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define CGC_GEN_BASE        12'h020
`define CGC_GEN_STRIDE      12'h004
`define CGC_STATUS_ADDR     12'h004
`define CGC_REQUEST_ADDR    12'h008
`define CGC_STANDBY_ADDR    12'h00C
`define CGC_NUM_GEN         12

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CGC_DIV_HI          31
`define CGC_DIV_LO          16
`define CGC_STANDBY_RUN     13
`define CGC_DIV_MODE        12
`define CGC_OUT_EN          11
`define CGC_OFF_LEVEL       10
`define CGC_DUTY_IMPROVE    9
`define CGC_GEN_EN          8
`define CGC_SRC_HI          4

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define CGC_RESET_GEN0      32'h00000106
`define CGC_RESET_OTHER     32'h00000000
`define CGC_CTRL_MASK       32'h00003F1F
`define CGC_DIV_MASK_WIDE   32'hFFFF0000
`define CGC_DIV_MASK_NARROW 32'h00FF0000
`define CGC_WIDE_GEN        1
`define CGC_SYNC_CYCLES     3

`endif

/* hdl/cgc_top.v */
/*
  Control logic for twelve programmable clock generators behind an
  AXI4-Lite slave. Each generator picks one of 32 source enables and
  divides it, producing one-cycle enable pulses and an output pin level.
  Assumes all sources are enable pulses in the I_CLK domain; standby
  and peripheral requests are synchronous levels.
*/
`timescale 1ns/1ps
`include "cgc_consts.vh"

// Operation
// (R1) Twelve generators, registers at 0x20 plus 4n
// (R2) Generator 1 has 16 div bits
// (R3) Unimplemented division bits are dropped on write
// (R4) Division value in bits 31:16, read/write
// (R5) Ratio depends on value and mode bit
// (R6) Standby-run plus output enable keeps running
// (R7) Without output enable, run only on request
// (R8) Generator 0 resets 0x106, others zero
// (R9) Mode 0 divide by value, else 2^(v+1)
// (R10) Writes settle after sync delay, busy shown
module cgc_top #(
  parameter NUM_GEN = `CGC_NUM_GEN
) (
  // Clock and reset
  input  wire        I_CLK,
  input  wire        I_SYS_RST,
  // AXI4-Lite write
  input  wire [11:0] I_AWADDR,
  input  wire        I_AWVALID,
  output reg         O_AWREADY,
  input  wire [31:0] I_WDATA,
  input  wire [3:0]  I_WSTRB,
  input  wire        I_WVALID,
  output reg         O_WREADY,
  output reg  [1:0]  O_BRESP,
  output reg         O_BVALID,
  input  wire        I_BREADY,
  // AXI4-Lite read
  input  wire [11:0] I_ARADDR,
  input  wire        I_ARVALID,
  output reg         O_ARREADY,
  output reg  [31:0] O_RDATA,
  output reg  [1:0]  O_RRESP,
  output reg         O_RVALID,
  input  wire        I_RREADY,
  // Clock sources and requests
  input  wire [31:0]      I_SRC_EN,
  input  wire [NUM_GEN-1:0] I_PERIPH_REQ,
  input  wire        I_STANDBY,
  // Generator outputs
  output reg  [NUM_GEN-1:0] O_GEN_TICK,
  output reg  [NUM_GEN-1:0] O_CLK_OUT,
  output reg  [NUM_GEN-1:0] O_CLK_OUT_EN
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [3:0] gen_index;
    input [11:0] addr;
    reg   [11:0] off;
    begin
      off       = addr - `CGC_GEN_BASE;
      gen_index = off[5:2];
    end
  endfunction

  function is_gen;
    input [11:0] addr;
    begin
      is_gen = (addr >= `CGC_GEN_BASE) && (addr < `CGC_GEN_BASE + 12'd48) && (addr[1:0] == 2'b00); // R1
    end
  endfunction

  // Full reload count: mode 0 value (0,1 undivided), mode 1 2^(v+1) for v up to 15, 0 at v=16, 0x1FFFF above 16
  function [16:0] div_count;
    input [15:0] dv;
    input        mode;
    begin
      if (!mode) begin
        div_count = (dv < 16'h0002) ? 17'h00001 : {1'b0, dv}; // R9
      end else if (dv > 16'h0010) begin
        div_count = 17'h1FFFF;
      end else begin
        div_count = 17'h00002 << dv[4:0]; // R9
      end
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [31:0] ctrl   [0:NUM_GEN-1];
  reg [31:0] active [0:NUM_GEN-1];
  reg [1:0]  busy_cnt [0:NUM_GEN-1];
  reg [16:0] cnt    [0:NUM_GEN-1];
  reg [NUM_GEN-1:0] busy;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg        aw_have;
  reg        w_have;
  reg [31:0] wmask;
  reg [31:0] merged;
  integer    i;
  integer    k;

  wire do_write = aw_have && w_have && !O_BVALID;
  wire [3:0] wgen = gen_index(aw_addr);

  always @* begin
    wmask  = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    merged = (ctrl[wgen] & ~wmask) | (w_data & wmask);
    merged = merged & (`CGC_CTRL_MASK | ((wgen == `CGC_WIDE_GEN) ? `CGC_DIV_MASK_WIDE
             : `CGC_DIV_MASK_NARROW)); // R2 R3 R4
  end

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= 2'b00;
      aw_have   <= 1'b0;
      w_have    <= 1'b0;
      aw_addr   <= 12'h000;
      w_data    <= 32'h00000000;
      w_strb    <= 4'h0;
      ctrl[0]   <= `CGC_RESET_GEN0; // R8
      for (k = 1; k < NUM_GEN; k = k + 1) begin
        ctrl[k] <= `CGC_RESET_OTHER; // R8
      end
    end else begin
      O_AWREADY <= !aw_have && !O_AWREADY && I_AWVALID;
      O_WREADY  <= !w_have && !O_WREADY && I_WVALID;
      if (I_AWVALID && O_AWREADY) begin
        aw_have <= 1'b1;
        aw_addr <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_have <= 1'b1;
        w_data <= I_WDATA;
        w_strb <= I_WSTRB;
      end
      if (do_write) begin
        aw_have  <= 1'b0;
        w_have   <= 1'b0;
        O_BVALID <= 1'b1;
        if (is_gen(aw_addr)) begin
          ctrl[wgen] <= merged; // R1
          O_BRESP    <= 2'b00;
        end else begin
          O_BRESP    <= 2'b10;
        end
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h00000000;
      O_RRESP   <= 2'b00;
    end else begin
      O_ARREADY <= !O_ARREADY && !O_RVALID && I_ARVALID;
      if (I_ARVALID && O_ARREADY) begin
        O_RVALID <= 1'b1;
        O_RRESP  <= 2'b00;
        if (is_gen(I_ARADDR)) begin
          O_RDATA <= ctrl[gen_index(I_ARADDR)]; // R4
        end else if (I_ARADDR == `CGC_STATUS_ADDR) begin
          O_RDATA <= {{(32-NUM_GEN){1'b0}}, busy}; // R10
        end else if (I_ARADDR == `CGC_REQUEST_ADDR) begin
          O_RDATA <= {{(32-NUM_GEN){1'b0}}, I_PERIPH_REQ};
        end else if (I_ARADDR == `CGC_STANDBY_ADDR) begin
          O_RDATA <= {31'h00000000, I_STANDBY};
        end else begin
          O_RDATA <= 32'h00000000;
          O_RRESP <= 2'b10;
        end
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Generators
  // ----------------------------------------
  // Settings reach the divider after a fixed delay, standing in for the
  // crossing into a real generator clock; software polls busy meanwhile.
  always @(posedge I_CLK) begin : gen_proc
    reg        run;
    reg [31:0] a;
    reg        src_tick;
    reg [16:0] full;
    for (i = 0; i < NUM_GEN; i = i + 1) begin
      if (I_SYS_RST) begin
        active[i]       <= (i == 0) ? `CGC_RESET_GEN0 : `CGC_RESET_OTHER;
        busy_cnt[i]     <= 2'b00;
        busy[i]         <= 1'b0;
        cnt[i]          <= 17'h00000;
        O_GEN_TICK[i]   <= 1'b0;
        O_CLK_OUT[i]    <= 1'b0;
        O_CLK_OUT_EN[i] <= 1'b0;
      end else begin
        a = active[i];
        if (active[i] != ctrl[i] && !busy[i]) begin
          busy[i]     <= 1'b1; // R10
          busy_cnt[i] <= 2'd`CGC_SYNC_CYCLES - 2'd1;
        end else if (busy[i] && busy_cnt[i] != 2'b00) begin
          busy_cnt[i] <= busy_cnt[i] - 2'd1;
        end else if (busy[i]) begin
          active[i] <= ctrl[i]; // R10
          busy[i]   <= 1'b0;
        end
        if (a[`CGC_OUT_EN]) begin
          run = a[`CGC_GEN_EN] && (!I_STANDBY || a[`CGC_STANDBY_RUN]); // R6
        end else begin
          run = a[`CGC_GEN_EN] && I_PERIPH_REQ[i]; // R7
        end
        src_tick = I_SRC_EN[a[`CGC_SRC_HI:0]];
        full     = div_count(a[`CGC_DIV_HI:`CGC_DIV_LO], a[`CGC_DIV_MODE]); // R5
        O_CLK_OUT_EN[i] <= a[`CGC_OUT_EN];
        O_GEN_TICK[i]   <= 1'b0;
        if (!run) begin
          cnt[i]       <= 17'h00000;
          O_CLK_OUT[i] <= a[`CGC_OFF_LEVEL];
        end else if (src_tick) begin
          if (cnt[i] + 17'h00001 >= full) begin
            cnt[i]        <= 17'h00000;
            O_GEN_TICK[i] <= 1'b1;
          end else begin
            cnt[i] <= cnt[i] + 17'h00001;
          end
          // Output high for the first half of the period
          O_CLK_OUT[i] <= (full == 17'h00001) ? ~O_CLK_OUT[i] : (cnt[i] + 17'h00001 < (full >> 1)) ||
                          (cnt[i] + 17'h00001 >= full);
        end
      end
    end
  end

endmodule // cgc_top

/* bench/cgc_checker.sv */
/* Checker for cgc_top: bus handshakes, reset, idle generator 0.
   Assumes bind to cgc_top. */
`timescale 1ns/1ps
module cgc_checker #(parameter NUM_GEN = 12) (
  input logic I_CLK, I_SYS_RST, I_AWVALID, O_AWREADY, O_WREADY, O_BVALID, I_BREADY,
  input logic I_ARVALID, O_ARREADY, O_RVALID, I_RREADY, I_STANDBY,
  input logic [1:0] O_BRESP,
  input logic [31:0] O_RDATA,
  input logic [NUM_GEN-1:0] I_PERIPH_REQ, O_GEN_TICK, O_CLK_OUT_EN
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // ----------
  // Properties
  // ----------
  bvalid_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID) else $error("bvalid dropped");
  rvalid_hold_a: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data not held");
  awready_pulse_a: assert property (O_AWREADY |=> !O_AWREADY) else $error("awready held");
  write_answer_a: assert property (O_AWREADY && I_AWVALID |-> ##[1:8] O_BVALID) else $error("no bvalid");
  read_answer_a: assert property (O_ARREADY && I_ARVALID |-> ##[1:4] O_RVALID) else $error("no rvalid");
  resp_cause_a: assert property ($rose(O_BVALID) |-> $past(O_WREADY) || $past(O_WREADY, 2))
    else $error("bvalid without write");
  reset_quiet_a: assert property ($past(I_SYS_RST) |-> O_GEN_TICK == 0 && O_CLK_OUT_EN == 0)
    else $error("outputs busy after reset");
  idle_gen_a: assert property ((!I_PERIPH_REQ[0] && !O_CLK_OUT_EN[0])[*8] |-> !O_GEN_TICK[0])
    else $error("unrequested generator ran");
  cover property (O_BVALID && I_BREADY && O_BRESP == 2'b10);
  cover property (O_RVALID && I_RREADY);
  cover property (I_STANDBY && O_GEN_TICK[1]);
endmodule // cgc_checker
bind cgc_top cgc_checker #(.NUM_GEN(NUM_GEN)) u_cgc_checker (.I_CLK, .I_SYS_RST, .I_AWVALID, .O_AWREADY,
  .O_WREADY, .O_BVALID, .I_BREADY, .I_ARVALID, .O_ARREADY, .O_RVALID, .I_RREADY, .I_STANDBY, .O_BRESP,
  .O_RDATA, .I_PERIPH_REQ, .O_GEN_TICK, .O_CLK_OUT_EN);

/* bench/cgc_periph.sv */
/* Far side: sources, peripheral requests, period meter on generator 1.
   Assumes ticks are one-cycle pulses on i_clk. */
`timescale 1ns/1ps
module cgc_periph (
  input  wire        i_clk, i_rst, i_clr,
  input  wire [11:0] i_want, i_tick,
  output wire [31:0] o_src_en,
  output wire [11:0] o_req,
  output reg  [15:0] o_per
);
  reg [15:0] cnt;
  reg        run;
  reg        half;
  // Source 1 undivided so periods equal the ratio
  assign o_src_en = {31'h7FFFFFFF, half};
  assign o_req = i_want;
  always @(posedge i_clk) begin
    half <= ~half & ~i_rst;
    cnt <= i_tick[1] ? 16'h0000 : cnt + 16'h0001;
    if (i_rst || i_clr) begin
      o_per <= 16'h0000;
      run <= 1'b0;
    end else if (i_tick[1]) begin
      if (run) o_per <= cnt + 16'h0001;
      run <= 1'b1;
    end
  end
endmodule // cgc_periph

/* bench/tb.sv */
/* Bench for cgc_top: register map over AXI4-Lite, division, standby.
   Assumes cgc_periph as far side. */
`timescale 1ns/1ps
module tb;
  logic I_CLK, I_SYS_RST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_STANDBY, clr;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic [11:0] I_AWADDR, I_ARADDR, want, I_PERIPH_REQ, O_GEN_TICK, O_CLK_OUT, O_CLK_OUT_EN;
  logic [31:0] I_WDATA, I_SRC_EN, O_RDATA;
  logic [3:0]  I_WSTRB;
  logic [1:0]  O_BRESP, O_RRESP;
  logic [15:0] per;
  int mismatches, n_tests;
  cgc_top u_cgc_top (.I_CLK, .I_SYS_RST, .I_AWADDR, .I_AWVALID, .O_AWREADY, .I_WDATA, .I_WSTRB,
    .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA,
    .O_RRESP, .O_RVALID, .I_RREADY, .I_SRC_EN, .I_PERIPH_REQ, .I_STANDBY, .O_GEN_TICK, .O_CLK_OUT,
    .O_CLK_OUT_EN);
  cgc_periph u_cgc_periph (.i_clk(I_CLK), .i_rst(I_SYS_RST), .i_clr(clr), .i_want(want),
    .i_tick(O_GEN_TICK), .o_src_en(I_SRC_EN), .o_req(I_PERIPH_REQ), .o_per(per));
  initial begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, s, x);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge I_CLK);
    I_AWADDR <= a;
    I_WDATA <= d;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge I_CLK);
      if (O_AWREADY && !ad) begin I_AWVALID <= 1'b0; ad = 1; end
      if (O_WREADY && !wd) begin I_WVALID <= 1'b0; wd = 1; end
    end
    while (!O_BVALID) @(posedge I_CLK);
    I_BREADY <= 1'b0;
    chk(O_BRESP, e);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge I_CLK);
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    do @(posedge I_CLK); while (!O_ARREADY);
    I_ARVALID <= 1'b0;
    while (!O_RVALID) @(posedge I_CLK);
    I_RREADY <= 1'b0;
    chk(O_RDATA, d);
    chk(O_RRESP, e);
  endtask
  // Program generator 1, restart the meter, read its period
  task tdiv(input logic [31:0] c, input logic [15:0] p);
    wr(12'h024, c, 2'b00);
    rd(12'h004, 32'h00000002, 2'b00);
    repeat (10) @(posedge I_CLK);
    rd(12'h004, 32'h00000000, 2'b00);
    clr <= 1'b1;
    @(posedge I_CLK);
    clr <= 1'b0;
    repeat (40) @(posedge I_CLK);
    chk({16'h0000, per}, {16'h0000, p});
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge I_CLK);
    mismatches++;
    give_verdict;
  end
  initial begin
    {I_SYS_RST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_STANDBY, clr} = 8'h80;
    {I_AWADDR, I_ARADDR, want, I_WDATA} = 68'h0;
    I_WSTRB = 4'hF;
    repeat (2) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    for (int i = 0; i < 12; i++) rd(12'h020 + 12'(4 * i), i == 0 ? 32'h00000106 : 32'h0, 2'b00);
    $display("reset values done");
    for (int i = 0; i < 12; i++) begin
      wr(12'h020 + 12'(4 * i), 32'hFFFFFFFF, 2'b00);
      rd(12'h020 + 12'(4 * i), (i == 1 ? 32'hFFFF0000 : 32'h00FF0000) | 32'h00003F1F, 2'b00);
    end
    rd(12'h050, 32'h0, 2'b10);
    wr(12'h050, 32'h00000001, 2'b10);
    $display("register map done");
    want <= 12'h002;
    rd(12'h008, 32'h00000002, 2'b00);
    tdiv(32'h00050101, 16'h0005);
    tdiv(32'h00021101, 16'h0008);
    want <= 12'h000;
    tdiv(32'h00050101, 16'h0000);
    chk(O_CLK_OUT[1], 32'h0);
    I_STANDBY <= 1'b1;
    rd(12'h00C, 32'h00000001, 2'b00);
    tdiv(32'h00042901, 16'h0004);
    chk(O_CLK_OUT_EN[1], 32'h1);
    $display("generators done");
    give_verdict;
  end
endmodule // tb
